// file: reset_and_interrupt_control.sv
// Reset sequencing, interrupt mask, request latching and vector selection
// for an 8-bit microcontroller core.
// Assumes the CPU reports opcode fetches and instruction boundaries, and that
// peripherals give one-cycle event pulses; the watchdog counter is outside.
//
// Functional notes
// - Four reset causes: power-on, pin, illegal fetch, watchdog.
// - Every reset vectors through 3FFE and sets mask.
// - Power-on holds reset 4064 cycles.
// - Pin still low extends power-on reset.
// - Reset sequence starts on clock after pin rise.
// - Fetch from unused or register space resets.
// - Watchdog always on; timeout resets, keeps mode.
// - Writing zero to 3FF0 bit 0 restarts watchdog.
// - Mask set blocks all maskable interrupts.
// - Accepted interrupt stacks state, sets mask.
// - Requests wait for instruction completion.
// - Software trap unmaskable, ordered after earlier requests.
// - Fixed priority: reset, trap, pin, sync, bus, timer.
// - Edge-only bit selects pin sensitivity.
// - Pin request vectors through 3FFA when unmasked.
// - Pin latch cleared at service, one more latchable.
// - Level mode rerequests while line stays low.
// - Sync enable bit 7; latch clears at vector.
// - Timer vector from overflow or periodic, gated.
// - Bus request from flag and enable; software clears.
`timescale 1ns/1ps
module reset_and_interrupt_control
(
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        reset_pin_n,
	input  wire logic        irq_pin_n,
	input  wire logic [15:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata_r,
	input  wire logic        fetch_valid,
	input  wire logic [15:0] fetch_addr,
	input  wire logic        swi_fetch,
	input  wire logic        insn_done,
	input  wire logic        mask_set,
	input  wire logic        mask_clear,
	input  wire logic        restore_valid,
	input  wire logic        restore_mask,
	input  wire logic        watchdog_timeout,
	input  wire logic        overflow_event,
	input  wire logic        periodic_event,
	input  wire logic        sync_event,
	input  wire logic        bus_event,
	output logic             cpu_reset_r,
	output logic             keep_mode_r,
	output logic             mask_r,
	output logic             service_r,
	output logic      [15:0] vector_addr_r,
	output logic             watchdog_restart_r,
	output logic      [1:0]  rate_select_r
);
	import ric_pkg::*;

	// ========================================================================
	// Pin synchronisers
	// ========================================================================
	logic rst_level;
	logic rst_rise;
	logic irq_level;
	logic irq_fall;

	pin_sync u_reset_sync
	(
		.mclk   (mclk),
		.resetn (resetn),
		.pin    (reset_pin_n),
		.level  (rst_level),
		.fall   (),
		.rise   (rst_rise)
	);

	pin_sync u_irq_sync
	(
		.mclk   (mclk),
		.resetn (resetn),
		.pin    (irq_pin_n),
		.level  (irq_level),
		.fall   (irq_fall),
		.rise   ()
	);

	// ========================================================================
	// Reset sequencer
	// ========================================================================
	rst_state_type state_r;
	rst_state_type state_nxt;
	logic [11:0]   cnt_r;
	logic [11:0]   cnt_nxt;
	logic          fetch_legal;
	logic          illegal_fetch;
	logic [3:0]    cause_r;

	// Register space and unused holes are not legal places for an opcode.
	assign fetch_legal = (fetch_addr >= RAM_LO && fetch_addr <= RAM_HI) ||
		(fetch_addr >= ROM_LO && fetch_addr <= ROM_HI) || (fetch_addr >= VEC_LO);
	assign illegal_fetch = fetch_valid && !fetch_legal;

	// Power-on is the asynchronous reset; the pin and internal causes follow.
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		case (state_r)
			RST_POR:
			begin
				cnt_nxt = cnt_r + 12'h001;
				if (cnt_r == POR_LAST)
				begin
					cnt_nxt   = 12'h000;
					state_nxt = rst_level ? RST_RUN : RST_PIN_HOLD;
				end
			end
			RST_PIN_HOLD:
			begin
				if (rst_level)
					state_nxt = RST_RUN;
			end
			RST_INTERNAL:
			begin
				cnt_nxt = cnt_r + 12'h001;
				if (cnt_r == INT_RST_LAST)
				begin
					cnt_nxt   = 12'h000;
					state_nxt = RST_RUN;
				end
			end
			RST_RUN:
			begin
				cnt_nxt = 12'h000;
				if (!rst_level)
					state_nxt = RST_PIN_HOLD;
				else if (illegal_fetch || watchdog_timeout)
					state_nxt = RST_INTERNAL;
			end
			default:
			begin
				state_nxt = RST_POR;
				cnt_nxt   = 12'h000;
			end
		endcase
	end

	// The reset output follows the next state so it rises with the cause.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_r     <= RST_POR;
			cnt_r       <= 12'h000;
			cpu_reset_r <= 1'b1;
		end
		else
		begin
			state_r     <= state_nxt;
			cnt_r       <= cnt_nxt;
			cpu_reset_r <= (state_nxt != RST_RUN);
		end
	end

	// Internal causes leave the operating mode alone; pin and power-on do not.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			keep_mode_r <= 1'b0;
			cause_r     <= 4'h8;
		end
		else if (state_r == RST_RUN && state_nxt == RST_PIN_HOLD)
		begin
			keep_mode_r <= 1'b0;
			cause_r     <= 4'h4;
		end
		else if (state_r == RST_RUN && state_nxt == RST_INTERNAL)
		begin
			keep_mode_r <= 1'b1;
			cause_r     <= illegal_fetch ? 4'h2 : 4'h1;
		end
	end

	// ========================================================================
	// Software registers
	// ========================================================================
	logic tof_r;
	logic periodic_interrupt_flag_r;
	logic tofie_r;
	logic rtie_r;
	logic edge_only_r;
	logic sync_en_r;
	logic mien_r;
	logic mif_r;
	logic wr_timer;
	logic wr_bus_stat;

	assign wr_timer    = reg_wr && reg_addr == ADDR_TIMER_CTRL;
	assign wr_bus_stat = reg_wr && reg_addr == ADDR_BUS_STAT;

	// Enables and selects; any reset returns them to their defaults.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			tofie_r       <= 1'b0;
			rtie_r        <= 1'b0;
			edge_only_r   <= 1'b0;
			rate_select_r <= RATE_RESET;
			sync_en_r     <= 1'b0;
			mien_r        <= 1'b0;
		end
		else if (cpu_reset_r)
		begin
			tofie_r       <= 1'b0;
			rtie_r        <= 1'b0;
			edge_only_r   <= 1'b0;
			rate_select_r <= RATE_RESET;
			sync_en_r     <= 1'b0;
			mien_r        <= 1'b0;
		end
		else
		begin
			if (wr_timer)
			begin
				tofie_r       <= reg_wdata[TOFIE_BIT];
				rtie_r        <= reg_wdata[RTIE_BIT];
				edge_only_r   <= reg_wdata[EDGE_BIT];
				rate_select_r <= reg_wdata[1:0];
			end
			if (reg_wr && reg_addr == ADDR_SYNC_CTRL)
				sync_en_r <= reg_wdata[SYNC_EN_BIT];
			if (reg_wr && reg_addr == ADDR_BUS_CTRL)
				mien_r <= reg_wdata[MIEN_BIT];
		end
	end

	// Hardware-set flags clear on a written zero; a same-cycle event wins.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			tof_r  <= 1'b0;
			periodic_interrupt_flag_r <= 1'b0;
			mif_r  <= 1'b0;
		end
		else if (cpu_reset_r)
		begin
			tof_r  <= 1'b0;
			periodic_interrupt_flag_r <= 1'b0;
			mif_r  <= 1'b0;
		end
		else
		begin
			tof_r  <= overflow_event | (tof_r & !(wr_timer & !reg_wdata[TOF_BIT]));
			periodic_interrupt_flag_r <= periodic_event | (periodic_interrupt_flag_r & !(wr_timer & !reg_wdata[PERIODIC_INTERRUPT_FLAG_BIT]));
			mif_r  <= bus_event | (mif_r & !(wr_bus_stat & !reg_wdata[MIF_BIT]));
		end
	end

	// Read data stand only in the cycle after the read strobe.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			reg_rdata_r <= 8'h00;
		else if (!reg_rd)
			reg_rdata_r <= 8'h00;
		else
		begin
			case (reg_addr)
				ADDR_TIMER_CTRL: reg_rdata_r <= {tof_r, periodic_interrupt_flag_r, tofie_r, rtie_r,
					edge_only_r, 1'b0, rate_select_r};
				ADDR_SYNC_CTRL:  reg_rdata_r <= {sync_en_r, 7'h00};
				ADDR_BUS_CTRL:   reg_rdata_r <= {1'b0, mien_r, 6'h00};
				ADDR_BUS_STAT:   reg_rdata_r <= {6'h00, mif_r, 1'b0};
				ADDR_RST_CAUSE:  reg_rdata_r <= {4'h0, cause_r};
				default:         reg_rdata_r <= 8'h00;
			endcase
		end
	end

	// A zero in bit 0 at the restart location feeds the outside counter.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			watchdog_restart_r <= 1'b0;
		else
			watchdog_restart_r <= reg_wr && reg_addr == ADDR_WDOG_CLR && !reg_wdata[0];
	end

	// ========================================================================
	// Request latches and priority
	// ========================================================================
	logic ext_latch_r;
	logic sync_latch_r;
	logic swi_pend_r;
	logic swi_prior_r;
	logic ext_req;
	logic sync_req;
	logic bus_req;
	logic timer_req;
	logic hw_any;
	logic boundary;
	logic take_swi;
	logic take_hw;
	logic [15:0] hw_vector;

	// Level mode also requests while the line is held low.
	assign ext_req   = ext_latch_r | (!edge_only_r & !irq_level);
	assign sync_req  = sync_latch_r & sync_en_r;
	assign bus_req   = mif_r & mien_r;
	assign timer_req = (tof_r & tofie_r) | (periodic_interrupt_flag_r & rtie_r);
	assign hw_any    = ext_req | sync_req | bus_req | timer_req;

	// Decisions happen only when an instruction completes.
	assign boundary = insn_done && !cpu_reset_r && !service_r;
	// The trap yields only to requests already pending at its fetch.
	assign take_swi = boundary && swi_pend_r && (mask_r || !(swi_prior_r && hw_any));
	assign take_hw  = boundary && !take_swi && !mask_r && hw_any;

	// Fixed order; lower requests remain latched for a later boundary.
	always_comb
	begin
		if (ext_req)
			hw_vector = VEC_EXT;
		else if (sync_req)
			hw_vector = VEC_SYNC;
		else if (bus_req)
			hw_vector = VEC_BUS;
		else
			hw_vector = VEC_TIMER;
	end

	// One latch bit: a single extra pulse may wait behind the current one.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			ext_latch_r  <= 1'b0;
			sync_latch_r <= 1'b0;
		end
		else if (cpu_reset_r)
		begin
			ext_latch_r  <= 1'b0;
			sync_latch_r <= 1'b0;
		end
		else
		begin
			ext_latch_r  <= irq_fall | (ext_latch_r & !(take_hw && ext_req));
			sync_latch_r <= sync_event |
				(sync_latch_r & !(take_hw && !ext_req && sync_req));
		end
	end

	// The trap snapshot records whether unmasked hardware was already waiting.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			swi_pend_r  <= 1'b0;
			swi_prior_r <= 1'b0;
		end
		else if (cpu_reset_r || take_swi)
		begin
			swi_pend_r  <= 1'b0;
			swi_prior_r <= 1'b0;
		end
		else if (swi_fetch)
		begin
			swi_pend_r  <= 1'b1;
			swi_prior_r <= hw_any && !mask_r;
		end
	end

	// ========================================================================
	// Service pulse, vector and interrupt mask
	// ========================================================================
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			service_r     <= 1'b0;
			vector_addr_r <= VEC_RESET;
		end
		else if (cpu_reset_r)
		begin
			service_r     <= 1'b0;
			vector_addr_r <= VEC_RESET;
		end
		else
		begin
			service_r <= take_swi | take_hw;
			if (take_swi)
				vector_addr_r <= VEC_SWI;
			else if (take_hw)
				vector_addr_r <= hw_vector;
		end
	end

	// Reset and service set the mask; restore from the stack comes next.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			mask_r <= 1'b1;
		else if (cpu_reset_r || take_swi || take_hw)
			mask_r <= 1'b1;
		else if (restore_valid)
			mask_r <= restore_mask;
		else if (mask_set)
			mask_r <= 1'b1;
		else if (mask_clear)
			mask_r <= 1'b0;
	end

	// ========================================================================
	// Checks
	// ========================================================================
	logic [12:0] up_cnt_r;

	// Counts cycles since power-on release, saturating past the delay.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			up_cnt_r <= 13'h0000;
		else if (up_cnt_r != 13'h1fff)
			up_cnt_r <= up_cnt_r + 13'h0001;
	end

	property p_por_hold;
		@(posedge mclk) disable iff (!resetn) (up_cnt_r < 13'(POR_CYCLES)) |-> cpu_reset_r;
	endproperty
	a_por_hold: assert property (p_por_hold) else $error("reset left before power-on delay");

	property p_pin_hold;
		@(posedge mclk) disable iff (!resetn)
			(state_r == RST_PIN_HOLD && !rst_level) |=> cpu_reset_r;
	endproperty
	a_pin_hold: assert property (p_pin_hold) else $error("reset dropped while pin low");

	property p_pin_release;
		@(posedge mclk) disable iff (!resetn)
			(state_r == RST_PIN_HOLD && rst_level) |=> !cpu_reset_r;
	endproperty
	a_pin_release: assert property (p_pin_release) else $error("late release after pin");

	property p_illegal;
		@(posedge mclk) disable iff (!resetn)
			(!cpu_reset_r && rst_level && illegal_fetch) |=> cpu_reset_r && keep_mode_r;
	endproperty
	a_illegal: assert property (p_illegal) else $error("illegal fetch without reset");

	property p_watchdog;
		@(posedge mclk) disable iff (!resetn)
			(!cpu_reset_r && rst_level && watchdog_timeout) |=> cpu_reset_r ##4 !cpu_reset_r;
	endproperty
	a_watchdog: assert property (p_watchdog) else $error("watchdog reset wrong length");

	property p_reset_vector;
		@(posedge mclk) disable iff (!resetn)
			$fell(cpu_reset_r) |-> mask_r && vector_addr_r == VEC_RESET;
	endproperty
	a_reset_vector: assert property (p_reset_vector) else $error("reset left no vector");

	property p_restart;
		@(posedge mclk) disable iff (!resetn)
			(reg_wr && reg_addr == ADDR_WDOG_CLR && !reg_wdata[0]) |=> watchdog_restart_r;
	endproperty
	a_restart: assert property (p_restart) else $error("watchdog restart missed");

	property p_masked;
		@(posedge mclk) disable iff (!resetn)
			(service_r && vector_addr_r != VEC_SWI) |-> !$past(mask_r) && $past(insn_done);
	endproperty
	a_masked: assert property (p_masked) else $error("masked request serviced");

	property p_service_mask;
		@(posedge mclk) disable iff (!resetn) service_r |-> mask_r ##1 !service_r;
	endproperty
	a_service_mask: assert property (p_service_mask) else $error("service left mask clear");

	property p_priority;
		@(posedge mclk) disable iff (!resetn)
			(service_r && vector_addr_r == VEC_BUS) |-> !$past(ext_req) && !$past(sync_req);
	endproperty
	a_priority: assert property (p_priority) else $error("lower request beat higher");

	property p_edge_only;
		@(posedge mclk) disable iff (!resetn)
			(edge_only_r && !ext_latch_r) |-> !ext_req;
	endproperty
	a_edge_only: assert property (p_edge_only) else $error("level seen in edge mode");

	c_pin_reset: cover property (@(posedge mclk) disable iff (!resetn) $fell(keep_mode_r));
	c_swi: cover property (@(posedge mclk) disable iff (!resetn)
		service_r && vector_addr_r == VEC_SWI);
	c_ext: cover property (@(posedge mclk) disable iff (!resetn)
		service_r && vector_addr_r == VEC_EXT);
	c_timer: cover property (@(posedge mclk) disable iff (!resetn)
		service_r && vector_addr_r == VEC_TIMER);
endmodule

// file: ric_pkg.sv
// Shared constants for the reset and interrupt controller: register map,
// field positions, reset values, vector addresses, memory map and timing.
// Assumes a 16-bit CPU address space and an 8-bit register data path.
package ric_pkg;

	// ========================================================================
	// Register map
	// ========================================================================
	localparam logic [15:0] ADDR_TIMER_CTRL = 16'h0008; // Timer control and status.
	localparam logic [15:0] ADDR_SYNC_CTRL  = 16'h0011; // Sync control register.
	localparam logic [15:0] ADDR_BUS_CTRL   = 16'h0019; // Two-wire bus control.
	localparam logic [15:0] ADDR_BUS_STAT   = 16'h001a; // Two-wire bus status.
	localparam logic [15:0] ADDR_RST_CAUSE  = 16'h0030; // Last reset cause.
	localparam logic [15:0] ADDR_WDOG_CLR   = 16'h3ff0; // Watchdog restart location.

	// ========================================================================
	// Field positions and reset values
	// ========================================================================
	localparam int TOF_BIT    = 7;
	localparam int PERIODIC_INTERRUPT_FLAG_BIT   = 6;
	localparam int TOFIE_BIT  = 5;
	localparam int RTIE_BIT   = 4;
	localparam int EDGE_BIT   = 3;
	localparam int SYNC_EN_BIT = 7;
	localparam int MIEN_BIT   = 6;
	localparam int MIF_BIT    = 1;
	localparam logic [1:0] RATE_RESET = 2'h3;

	// ========================================================================
	// Vector addresses (address of the high byte of each pair)
	// ========================================================================
	localparam logic [15:0] VEC_RESET = 16'h3ffe;
	localparam logic [15:0] VEC_SWI   = 16'h3ffc;
	localparam logic [15:0] VEC_EXT   = 16'h3ffa;
	localparam logic [15:0] VEC_SYNC  = 16'h3ff8;
	localparam logic [15:0] VEC_BUS   = 16'h3ff6;
	localparam logic [15:0] VEC_TIMER = 16'h3ff4;

	// ========================================================================
	// Memory map regions from which an opcode fetch is legal
	// ========================================================================
	localparam logic [15:0] RAM_LO = 16'h0080;
	localparam logic [15:0] RAM_HI = 16'h017f;
	localparam logic [15:0] ROM_LO = 16'h2000;
	localparam logic [15:0] ROM_HI = 16'h3eff;
	localparam logic [15:0] VEC_LO = 16'h3ff0;

	// ========================================================================
	// Timing
	// ========================================================================
	localparam int CLK_PERIOD_NS    = 10;
	localparam int POR_CYCLES       = 4064; // Counted in internal cycles.
	localparam int INT_RESET_CYCLES = 4;    // Hold time of an internal reset.
	localparam logic [11:0] POR_LAST     = 12'(POR_CYCLES - 1);
	localparam logic [11:0] INT_RST_LAST = 12'(INT_RESET_CYCLES - 1);

	// ========================================================================
	// Reset sequencer states
	// ========================================================================
	typedef enum logic [1:0] {RST_POR, RST_PIN_HOLD, RST_INTERNAL, RST_RUN} rst_state_type;

endpackage

// file: pin_sync.sv
// Two-stage synchroniser for one asynchronous pin with edge detection.
// Assumes the pin idles high; edges are seen in the same cycle as the level change.
`timescale 1ns/1ps
module pin_sync
(
	input  wire logic mclk,
	input  wire logic resetn,
	input  wire logic pin,
	output logic      level,
	output logic      fall,
	output logic      rise
);
	logic meta_r;
	logic sync_r;
	logic prev_r;

	// Only sync_r reads meta_r, so a metastable value never reaches logic.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_r <= 1'b1;
			sync_r <= 1'b1;
			prev_r <= 1'b1;
		end
		else
		begin
			meta_r <= pin;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// Edges compare the settled stage with its delayed copy.
	assign level = sync_r;
	assign fall  = prev_r & ~sync_r;
	assign rise  = ~prev_r & sync_r;
endmodule

// file: cpu_model.sv
// Behavioural model of the CPU core facing the reset and interrupt controller.
// Assumes service_r pulses once for each accepted request.
`timescale 1ns/1ps
module cpu_model
#(
	parameter int DELAY   = 2,
	parameter int ROUTINE = 6
)
(
	input  wire logic mclk,
	input  wire logic resetn,
	input  wire logic step,
	input  wire logic service_r,
	output logic      insn_done,
	output logic      restore_valid,
	output logic      restore_mask
);
	// ========================================================================
	// Instruction and service routine timing
	// ========================================================================
	int done_cnt;
	int rti_cnt;

	// The routine always returns to a state with the mask clear.
	assign restore_mask = 1'b0;

	// An instruction completes a few cycles after it is requested, never at once.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			done_cnt  <= 0;
			insn_done <= 1'b0;
		end
		else
		begin
			insn_done <= (done_cnt == 1);
			if (step)
				done_cnt <= DELAY;
			else if (done_cnt != 0)
				done_cnt <= done_cnt - 1;
		end
	end

	// Each service runs a routine of fixed length, then returns.
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			rti_cnt       <= 0;
			restore_valid <= 1'b0;
		end
		else
		begin
			restore_valid <= (rti_cnt == 1);
			if (service_r)
				rti_cnt <= ROUTINE;
			else if (rti_cnt != 0)
				rti_cnt <= rti_cnt - 1;
		end
	end
endmodule

// file: tb.sv
// Self-checking testbench for the reset and interrupt controller.
// Assumes cpu_model stands in for the CPU core on the far side.
`timescale 1ns/1ps
module tb;
	import ric_pkg::*;
	// ========================================================================
	// Stimulus and result signals
	// ========================================================================
	localparam logic [9:0] MSET = 10'h001, MCLR = 10'h002, TRAP = 10'h004;
	localparam logic [9:0] FETCH = 10'h008, WDOG = 10'h010, SYNC = 10'h020;
	localparam logic [9:0] BUS = 10'h040, OVF = 10'h080, PER = 10'h100;
	localparam logic [9:0] STEP = 10'h200;
	logic        mclk;
	logic        resetn;
	logic        reset_pin_n;
	logic        irq_pin_n;
	logic [15:0] reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] fetch_addr;
	logic [9:0]  ctl;
	logic        rd_d;
	logic [7:0]  reg_rdata_r;
	logic        cpu_reset_r;
	logic        keep_mode_r;
	logic        mask_r;
	logic        service_r;
	logic [15:0] vector_addr_r;
	logic        watchdog_restart_r;
	logic [1:0]  rate_select_r;
	logic        insn_done;
	logic        restore_valid;
	logic        restore_mask;
	logic [15:0] q[$];
	int          seed;
	int          fails;
	int          n_compared;
	int          n;
	int          i;
	logic [7:0]  w;

	reset_and_interrupt_control i_dut
	(
		.mclk(mclk), .resetn(resetn), .reset_pin_n(reset_pin_n), .irq_pin_n(irq_pin_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_r(reg_rdata_r), .fetch_valid(ctl[3]), .fetch_addr(fetch_addr),
		.swi_fetch(ctl[2]), .insn_done(insn_done), .mask_set(ctl[0]), .mask_clear(ctl[1]),
		.restore_valid(restore_valid), .restore_mask(restore_mask),
		.watchdog_timeout(ctl[4]), .overflow_event(ctl[7]), .periodic_event(ctl[8]),
		.sync_event(ctl[5]), .bus_event(ctl[6]), .cpu_reset_r(cpu_reset_r),
		.keep_mode_r(keep_mode_r), .mask_r(mask_r), .service_r(service_r),
		.vector_addr_r(vector_addr_r), .watchdog_restart_r(watchdog_restart_r),
		.rate_select_r(rate_select_r)
	);

	cpu_model i_cpu
	(
		.mclk(mclk), .resetn(resetn), .step(ctl[9]), .service_r(service_r),
		.insn_done(insn_done), .restore_valid(restore_valid), .restore_mask(restore_mask)
	);

	// ========================================================================
	// Shared tasks
	// ========================================================================
	task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		n_compared++;
		if (s !== e)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask

	// A result with no note waiting is compared against unknown, so it fails.
	task take(input string nm, input logic [15:0] s);
		chk(nm, (q.size() != 0) ? q.pop_front() : 16'hxxxx, s);
	endtask

	task tick(input int k);
		repeat (k) @(posedge mclk);
	endtask

	task pulse(input logic [9:0] m);
		ctl <= m;
		tick(1);
		ctl <= '0;
		tick(1);
	endtask

	task wr(input logic [15:0] a, input logic [7:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		tick(1);
		reg_wr <= 1'b0;
		tick(1);
	endtask

	task rd(input logic [15:0] a, input logic [7:0] e);
		q.push_back({8'h00, e});
		reg_addr <= a;
		reg_rd   <= 1'b1;
		tick(1);
		reg_rd <= 1'b0;
		tick(1);
	endtask

	// Bounded wait for the mask or the CPU reset to reach a level.
	task settle(input bit on_mask, input logic v, input int lim);
		n = 0;
		while (((on_mask ? mask_r : cpu_reset_r) !== v) && n < lim)
		begin
			tick(1);
			n++;
		end
	endtask

	task svc(input logic [15:0] v);
		q.push_back(v);
		pulse(STEP);
		settle(1'b1, 1'b1, 20);
		settle(1'b1, 1'b0, 40);
	endtask

	// A boundary at which nothing may be taken.
	task idle();
		pulse(STEP);
		tick(12);
	endtask

	task irq_pulse();
		irq_pin_n <= 1'b0;
		tick(3);
		irq_pin_n <= 1'b1;
		tick(3);
	endtask

	task report_and_stop();
		if (q.size() != 0)
			fails++;
		$display("compared %0d fails %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ========================================================================
	// Clock, watchdog and result monitor
	// ========================================================================
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Cuts the run short if any wait hangs well beyond the expected length.
	initial
	begin
		#(12000 * CLK_PERIOD_NS);
		fails++;
		report_and_stop();
	end

	always @(posedge mclk)
		rd_d <= reg_rd;

	// Results are looked at mid-cycle, where registered outputs have settled.
	always @(negedge mclk)
	begin
		if (rd_d === 1'b1)
			take("read data", {8'h00, reg_rdata_r});
		if (service_r === 1'b1)
		begin
			take("vector", vector_addr_r);
			chk("mask at service", 16'h1, {15'h0, mask_r});
		end
		if (watchdog_restart_r === 1'b1)
			take("restart", 16'h0001);
	end

	// ========================================================================
	// Main sequence
	// ========================================================================
	initial
	begin
		seed = 99;
		fails = 0;
		n_compared = 0;
		ctl = '0;
		resetn = 1'b0;
		reset_pin_n = 1'b1;
		irq_pin_n = 1'b1;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		fetch_addr = '0;
		tick(6);
		resetn <= 1'b1;
		settle(1'b0, 1'b0, 5000);
		chk("power-on hold", 16'h1, {15'h0, n >= 4063 && n <= 4066});
		chk("reset mask", 16'h1, {15'h0, mask_r});
		rd(ADDR_TIMER_CTRL, 8'h03);
		rd(ADDR_RST_CAUSE, 8'h08);
		w = 8'($random(seed)) & 8'h3b;
		wr(ADDR_TIMER_CTRL, w);
		rd(ADDR_TIMER_CTRL, w);
		chk("rate", {14'h0, w[1:0]}, {14'h0, rate_select_r});
		rd(16'h0040, 8'h00);
		wr(ADDR_WDOG_CLR, 8'h01);
		q.push_back(16'h0001);
		wr(ADDR_WDOG_CLR, 8'hfe);
		// Three sources pend under the mask, then leave one per boundary.
		wr(ADDR_SYNC_CTRL, 8'h80);
		wr(ADDR_BUS_CTRL, 8'h40);
		wr(ADDR_TIMER_CTRL, 8'h1b);
		pulse(SYNC | BUS | PER);
		idle();
		pulse(MCLR);
		svc(VEC_SYNC);
		svc(VEC_BUS);
		rd(ADDR_BUS_STAT, 8'h02);
		wr(ADDR_BUS_STAT, 8'h00);
		svc(VEC_TIMER);
		// The overflow flag alone must also reach the shared timer vector.
		wr(ADDR_TIMER_CTRL, 8'h2b);
		pulse(OVF);
		svc(VEC_TIMER);
		rd(ADDR_TIMER_CTRL, 8'hab);
		wr(ADDR_TIMER_CTRL, 8'h1b);
		idle();
		irq_pulse();
		svc(VEC_EXT);
		pulse(MSET);
		irq_pulse();
		irq_pulse();
		pulse(MCLR);
		svc(VEC_EXT);
		idle();
		irq_pulse();
		pulse(TRAP);
		svc(VEC_EXT);
		svc(VEC_SWI);
		pulse(MSET);
		pulse(TRAP);
		svc(VEC_SWI);
		wr(ADDR_TIMER_CTRL, 8'h03);
		irq_pin_n <= 1'b0;
		svc(VEC_EXT);
		svc(VEC_EXT);
		irq_pin_n <= 1'b1;
		tick(4);
		// Illegal fetch, then watchdog timeout: internal resets that keep the mode.
		for (i = 0; i < 2; i++)
		begin
			wr(ADDR_TIMER_CTRL, 8'h18);
			fetch_addr <= 16'($random(seed)) & 16'h002f;
			pulse(i == 0 ? FETCH : WDOG);
			tick(1);
			chk("internal reset", 16'h1, {15'h0, cpu_reset_r});
			chk("keep mode", 16'h1, {15'h0, keep_mode_r});
			chk("reset vector", VEC_RESET, vector_addr_r);
			chk("reset mask", 16'h1, {15'h0, mask_r});
			settle(1'b0, 1'b0, 20);
			rd(ADDR_TIMER_CTRL, 8'h03);
			rd(ADDR_RST_CAUSE, (i == 0) ? 8'h02 : 8'h01);
		end
		reset_pin_n <= 1'b0;
		tick(5);
		chk("pin reset", 16'h1, {15'h0, cpu_reset_r});
		chk("pin keep mode", 16'h0, {15'h0, keep_mode_r});
		reset_pin_n <= 1'b1;
		settle(1'b0, 1'b0, 10);
		chk("pin release", 16'h1, {15'h0, n <= 6});
		rd(ADDR_RST_CAUSE, 8'h04);
		report_and_stop();
	end
endmodule
